/* File: shared/mix_routing_pkg.sv */
// Summary of operation
// - Reg 0x11 bits 7:4 third mic left level
// - Codes 0 to 8 attenuate 1.5 dB steps
// - Gain code connects input; all ones disconnects
// - Reg 0x11 bits 3:0 third mic right level
// - Reg 0x12 bits 7:4 mic left, right mix
// - Reg 0x12 bits 3:0 mic right, right mix
// - Reg 0x13 bit 7 differential line mode
// - Reg 0x13 bits 6:3 line level, left mix
// - Reg 0x13 bit 2 left ADC power
// - Bits 1:0 stepping rate: every fs, every second fs, off
// - Gain 7-bit, 0.5 dB steps, saturates 59.5
package mix_routing_pkg;

  // ==========================================================
  // Register map (offsets are word indices; byte address = 4x)
  localparam logic [7:0] IDX_MIC_LEFT_MIX  = 8'h11;
  localparam logic [7:0] IDX_MIC_RIGHT_MIX = 8'h12;
  localparam logic [7:0] IDX_LINE_LEFT     = 8'h13;
  localparam logic [7:0] IDX_GAIN_TARGET   = 8'h40;
  localparam logic [7:0] IDX_GAIN_STATUS   = 8'h41;
  localparam int         ADDR_W            = 10;

  // ==========================================================
  // Reset values and field layout
  localparam logic [7:0] RST_MIC_MIX   = 8'hFF;
  localparam logic [7:0] RST_LINE_CTRL = 8'h78;
  localparam logic [6:0] RST_GAIN      = 7'h00;
  localparam logic [3:0] LEVEL_OFF     = 4'hF;
  localparam logic [3:0] LEVEL_MAX     = 4'h8;
  localparam logic [6:0] GAIN_SAT      = 7'h77;
  localparam int         DIFF_BIT      = 7;
  localparam int         POWER_BIT     = 2;

  typedef enum logic [1:0]
  {
    STEP_EVERY_FS = 2'b00,
    STEP_TWO_FS   = 2'b01,
    STEP_OFF_A    = 2'b10,
    STEP_OFF_B    = 2'b11
  } step_rate_t;

  // Decoded input: connect flag plus attenuation in 1.5 dB steps
  typedef struct packed
  {
    logic       connect;
    logic [3:0] atten_steps;
  } input_route_t;

endpackage

/* File: hdl/adc_input_mix_routing_regs.sv */
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
module adc_input_mix_routing_regs
  import mix_routing_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  // Sample rate strobe
  input  wire logic              fs_strobe,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic [31:0]            readdata,
  output logic                   waitrequest,
  output logic [1:0]             response,
  // Mixer routing to the analog side
  output input_route_t           mic_l_to_left,
  output input_route_t           mic_r_to_left,
  output input_route_t           mic_l_to_right,
  output input_route_t           mic_r_to_right,
  output input_route_t           line_l_to_left,
  output logic                   line_l_differential,
  output logic                   left_adc_power,
  output logic [6:0]             left_gain_applied
);

  // ==========================================================
  // Helpers
  // Reserved codes 9 to 14 are clamped to LEVEL_MAX: they decode as code 8.
  // level decode
  function automatic input_route_t decode_level(input logic [3:0] code);
    input_route_t r;
    r.connect     = 1'b0;
    r.atten_steps = 4'h0;
    if (code != LEVEL_OFF)
    begin
      r.connect     = 1'b1;
      r.atten_steps = (code > LEVEL_MAX) ? LEVEL_MAX : code;
    end
    return r;
  endfunction

  function automatic logic [6:0] sat_gain(input logic [6:0] g);
    return (g >= GAIN_SAT) ? GAIN_SAT : g;
  endfunction

  // ==========================================================
  // Register storage
  logic [7:0] mic_left_mix;
  logic [7:0] mic_right_mix;
  logic [7:0] line_left_ctrl;
  logic [6:0] gain_target;
  logic       half_fs;

  logic [7:0] word_index;
  logic       access_ok;
  logic       wr_go;
  logic       rd_go;

  assign word_index = address[9:2];
  assign access_ok  = (address[1:0] == 2'b00);
  // One-cycle wait: request taken on the edge where waitrequest is low
  assign wr_go = write && !waitrequest;
  assign rd_go = read && !waitrequest;

  // ==========================================================
  // Bus handshake
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      waitrequest <= 1'b1;
    else if ((read || write) && waitrequest)
      waitrequest <= 1'b0;
    else
      waitrequest <= 1'b1;
  end

  // ==========================================================
  // Register writes (byte lane 0 only carries data)
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mic_left_mix   <= RST_MIC_MIX;
      mic_right_mix  <= RST_MIC_MIX;
      line_left_ctrl <= RST_LINE_CTRL;
      gain_target    <= RST_GAIN;
    end
    else if (wr_go && access_ok && byteenable[0])
    begin
      case (word_index)
        IDX_MIC_LEFT_MIX:  mic_left_mix <= writedata[7:0];
        IDX_MIC_RIGHT_MIX: mic_right_mix <= writedata[7:0];
        IDX_LINE_LEFT:     line_left_ctrl <= writedata[7:0];
        IDX_GAIN_TARGET:   gain_target <= writedata[6:0];
        default:           ;
      endcase
    end
  end

  // ==========================================================
  // Read data and response
  // Captured on the edge that drops waitrequest, so they already
  // stand at the edge where the master samples waitrequest low.
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      readdata <= 32'h0000_0000;
      response <= 2'b00;
    end
    else if ((read || write) && waitrequest)
    begin
      readdata <= 32'h0000_0000;
      response <= 2'b00;
      if (!access_ok)
        response <= 2'b11;
      else
      begin
        case (word_index)
          IDX_MIC_LEFT_MIX:  readdata[7:0] <= mic_left_mix;
          IDX_MIC_RIGHT_MIX: readdata[7:0] <= mic_right_mix;
          IDX_LINE_LEFT:     readdata[7:0] <= line_left_ctrl;
          IDX_GAIN_TARGET:   readdata[6:0] <= gain_target;
          IDX_GAIN_STATUS:   readdata[6:0] <= left_gain_applied;
          default:           response <= 2'b11;
        endcase
      end
    end
  end

  // ==========================================================
  // Routing outputs, registered one cycle after the write
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mic_l_to_left       <= '0;
      mic_r_to_left       <= '0;
      mic_l_to_right      <= '0;
      mic_r_to_right      <= '0;
      line_l_to_left      <= '0;
      line_l_differential <= 1'b0;
      left_adc_power      <= 1'b0;
    end
    else
    begin
      mic_l_to_left       <= decode_level(mic_left_mix[7:4]);
      mic_r_to_left       <= decode_level(mic_left_mix[3:0]);
      mic_l_to_right      <= decode_level(mic_right_mix[7:4]);
      mic_r_to_right      <= decode_level(mic_right_mix[3:0]);
      line_l_to_left      <= decode_level(line_left_ctrl[6:3]);
      line_l_differential <= line_left_ctrl[DIFF_BIT];
      left_adc_power      <= line_left_ctrl[POWER_BIT];
    end
  end

  // ==========================================================
  // Gain soft-stepping
  step_rate_t rate;
  logic [6:0] target_sat;
  logic       step_now;

  assign rate       = step_rate_t'(line_left_ctrl[1:0]);
  assign target_sat = sat_gain(gain_target);
  assign step_now = fs_strobe &&
                    ((rate == STEP_EVERY_FS) ||
                     (rate == STEP_TWO_FS && half_fs));

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      half_fs <= 1'b0;
    else if (fs_strobe)
      half_fs <= !half_fs;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      left_gain_applied <= RST_GAIN;
    else if (line_left_ctrl[1])
      left_gain_applied <= target_sat;
    else if (step_now && left_gain_applied < target_sat)
      left_gain_applied <= left_gain_applied + 7'd1;
    else if (step_now && left_gain_applied > target_sat)
      left_gain_applied <= left_gain_applied - 7'd1;
  end

endmodule

/* File: test/mix_regs_sva.sv */
`timescale 1ns/1ps
// ====
// Bus handshake and routing checks
module mix_regs_sva
  import mix_routing_pkg::*;
(
  // Clock, reset and bus
  input wire logic              clk_sys,
  input wire logic              arst_n,
  input wire logic [ADDR_W-1:0] address,
  input wire logic              read,
  input wire logic              write,
  input wire logic              waitrequest,
  input wire logic [1:0]        response,
  input wire logic [31:0]       readdata,
  // Routing and gain
  input wire input_route_t      mic_l_to_left,
  input wire input_route_t      line_l_to_left,
  input wire logic [6:0]        left_gain_applied
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  logic       taken;
  logic       mapped;
  logic [1:0] up;
  assign taken = (read || write) && !waitrequest;
  assign mapped = address[1:0] == 2'b00
    && address[9:2] inside {8'h11, 8'h12, 8'h13, 8'h40, 8'h41};
  // Routing may move once after reset without any write
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      up <= 2'h0;
    else if (up != 2'h3)
      up <= up + 2'h1;
  chk_wait_pulse:
    assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low two cycles");
  chk_wait_cause:
    assert property (!waitrequest |-> read || write)
      else $error("waitrequest low with no request");
  chk_req_answer:
    assert property ((read || write) && waitrequest |-> ##[1:2] !waitrequest)
      else $error("request not answered");
  chk_bad_resp:
    assert property (taken && !mapped |=> response == 2'b11)
      else $error("unmapped access not refused");
  chk_rd_upper:
    assert property (read && !waitrequest |=> readdata[31:8] == 24'h0)
      else $error("read data upper bits set");
  chk_gain_sat:
    assert property (left_gain_applied <= GAIN_SAT)
      else $error("gain above saturation");
  chk_level_range:
    assert property (mic_l_to_left.connect |-> mic_l_to_left.atten_steps <= 4'h8)
      else $error("mic level out of range");
  chk_route_cause:
    assert property (up == 2'h3 && $changed(line_l_to_left)
      |-> $past(taken, 2) || $past(taken, 1))
      else $error("routing moved without write");
endmodule
bind adc_input_mix_routing_regs mix_regs_sva chk (.clk_sys, .arst_n,
  .address, .read, .write, .waitrequest, .response, .readdata,
  .mic_l_to_left, .line_l_to_left, .left_gain_applied);

/* File: test/test_adc_input_mix_routing_regs.sv */
`timescale 1ns/1ps
module test_adc_input_mix_routing_regs;
  import mix_routing_pkg::*;
  logic              clk_sys = 0;
  logic              arst_n = 0;
  logic              fs_strobe = 0;
  logic [ADDR_W-1:0] address = '0;
  logic              read = 0;
  logic              write = 0;
  logic [31:0]       writedata = 32'h0;
  logic [31:0]       readdata;
  logic              waitrequest;
  logic [1:0]        response;
  input_route_t      rt [5];
  logic              dif;
  logic              pwr;
  logic [6:0]        gain;
  logic [7:0]        q;
  logic [3:0]        lv [5];
  logic [3:0]        fsc = 4'h0;
  logic [6:0]        t;
  logic [6:0]        e;
  int                n_errors = 0;
  int                compares = 0;
  int                fsn = 0;
  int                i;
  int                k;
  int                n;
  int                f;
  adc_input_mix_routing_regs dut (.clk_sys, .arst_n, .fs_strobe, .address,
    .read, .write, .writedata, .byteenable(4'hf), .readdata, .waitrequest,
    .response, .mic_l_to_left(rt[0]), .mic_r_to_left(rt[1]),
    .mic_l_to_right(rt[2]), .mic_r_to_right(rt[3]), .line_l_to_left(rt[4]),
    .line_l_differential(dif), .left_adc_power(pwr),
    .left_gain_applied(gain));
  initial forever #20 clk_sys = ~clk_sys;
  // Sample strobe once every 16 cycles
  always @(posedge clk_sys)
  begin
    fsc <= fsc + 4'h1;
    fs_strobe <= fsc == 4'hf;
    if (fs_strobe)
      fsn <= fsn + 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Request held until waitrequest is sampled low; data taken there
  task automatic acc(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_sys);
    address <= {idx, 2'b00};
    writedata <= {24'h0, d};
    write <= wr;
    read <= !wr;
    i = 0;
    do
    begin
      @(posedge clk_sys);
      i++;
    end
    while (waitrequest !== 1'b0 && i < 9);
    q = readdata[7:0];
    write <= 0;
    read <= 0;
    if (waitrequest !== 1'b0)
    begin
      n_errors++;
      end_of_test;
    end
  endtask
  // Level codes 0 to 8 or disconnected only
  function automatic logic [3:0] pick();
    int v;
    v = $urandom_range(9, 0);
    return v == 9 ? 4'hf : v[3:0];
  endfunction
  function automatic logic [4:0] dec(input logic [3:0] c);
    return c == 4'hf ? 5'h0 : {1'b1, c};
  endfunction
  initial
  begin
    void'($urandom(32'h8cbe));
    repeat (2) @(posedge clk_sys);
    arst_n <= 1;
    acc(0, 8'h11, 0);
    chk(q, 8'hff);
    acc(0, 8'h12, 0);
    chk(q, 8'hff);
    acc(0, 8'h13, 0);
    chk({q, dif, pwr}, 10'h1e0);
    repeat (20)
    begin
      for (k = 0; k < 5; k++)
        lv[k] = pick();
      f = $urandom;
      acc(1, 8'h11, {lv[0], lv[1]});
      acc(1, 8'h12, {lv[2], lv[3]});
      acc(1, 8'h13, {f[1], lv[4], f[0], 2'b10});
      acc(0, 8'h13, 0);
      chk(q, {f[1], lv[4], f[0], 2'b10});
      chk({dif, pwr}, f[1:0]);
      for (k = 0; k < 5; k++)
        chk({rt[k].connect, rt[k].connect ? rt[k].atten_steps : 4'h0},
          dec(lv[k]));
    end
    acc(1, 8'h50, 8'h5a);
    chk(response, 2'b11);
    acc(0, 8'h14, 0);
    chk({response, q}, 10'h300);
    for (k = 0; k < 4; k++)
    begin
      acc(1, 8'h13, {6'h1f, 2'(8'b11_01_00_10 >> (2 * k))});
      t = k == 0 ? 7'h7f : k == 1 ? 7'h74 : k == 2 ? 7'h70 : 7'($urandom);
      e = t > 7'h77 ? 7'h77 : t;
      n = gain > e ? gain - e : e - gain;
      acc(1, 8'h40, {1'b0, t});
      f = fsn;
      for (i = 0; i < 400 && gain !== e; i++)
        @(negedge clk_sys);
      if (i == 400)
      begin
        n_errors++;
        end_of_test;
      end
      f = fsn - f;
      chk(k == 1 ? f >= n - 1 && f <= n + 1 : k == 2 ?
        f >= 2 * n - 2 && f <= 2 * n + 1 : f <= 1, 1);
      acc(0, 8'h41, 0);
      chk(q, e);
    end
    end_of_test;
  end
endmodule
